// ==== logic/drive_io_sampling_capture.sv ====
`timescale 1ns/10ps
// Operation
// RL1: Sample analog input 500us, or 125us fast.
// RL2: Analog value is sign plus 14 bits.
// RL3: Fault assignment opens contact on error.
// RL4: Contact closed when energized; writes immediate.
// RL5: Enable assignment drives contact from enable.
// RL6: Eight inputs plus enable, sampled 2ms.
// RL7: Each sampled input readable individually.
// RL8: Per-input polarity applied to sampled level.
// RL9: Follow mode: input a is pulse.
// RL10: Direction high forward, low reverse.
// RL11: Follow mode ignores connector pulse inputs.
// RL12: Capture axis position on fast trigger.
// RL13: Aux position capture only on input b.
// RL14: Captured value ready within one microsecond.
// RL15: Short trigger pulses latched reliably.
// RL16: Latch holds value until software clears; a hit on input b in axis mode overwrites the held axis value.
// RL17: Axis fast input may start moves.
// RL18: Synchronize fast input, detect edge, latch.
module drive_io_sampling_capture #(
    parameter int unsigned AIN_SW_CYCLES = drive_io_pkg::AIN_SW_CYC,
    parameter int unsigned AIN_HS_CYCLES = drive_io_pkg::AIN_HS_CYC,
    parameter int unsigned DIN_CYCLES = drive_io_pkg::DIN_SAMPLE_CYC,
    parameter int unsigned NUM_DIN = 8,
    parameter int unsigned POS_W = 32
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [14:0] command_analog_input,
    input wire logic [NUM_DIN-1:0] general_digital_inputs,
    input wire logic drive_enable_input,
    input wire logic global_error,
    input wire logic axis_enable_state,
    input wire logic [POS_W-1:0] axis_position,
    input wire logic [POS_W-1:0] aux_position,
    input wire logic conn_pulse,
    input wire logic conn_direction,
    output logic contact_energize,
    output logic [14:0] ain_fast_value,
    output logic follow_step,
    output logic follow_forward,
    output logic move_start,
    output logic enable_input_state
);
    typedef struct packed {
        logic [31:0] ack_data;
        logic ack;
        logic [7:0] ctrl;
        logic [NUM_DIN-1:0] polarity;
        logic [NUM_DIN-1:0] din;
        logic en_in;
        logic [14:0] ain_sw;
        logic [14:0] ain_hs;
        logic [31:0] ain_sw_cnt;
        logic [31:0] ain_hs_cnt;
        logic [31:0] din_cnt;
        logic [POS_W-1:0] cap_axis;
        logic [POS_W-1:0] cap_aux;
        logic contact;
        logic pulse_prev;
        logic step;
        logic fwd;
        logic start;
    } top_s;
    top_s st_q;
    top_s st_d;
    logic [NUM_DIN-1:0] din_active;
    logic wr;
    logic rd;
    logic pulse_src;
    logic dir_src;
    capture_if cap_a ();
    capture_if cap_b ();
    fast_capture u_cap_a (
        .core_clk(core_clk),
        .resetn(resetn),
        .cp(cap_a.cap)
    );
    fast_capture u_cap_b (
        .core_clk(core_clk),
        .resetn(resetn),
        .cp(cap_b.cap)
    );
    // Inputs go to the capture stages raw; their synchronizers sit inside
    assign cap_a.raw_in = general_digital_inputs[4];
    assign cap_b.raw_in = general_digital_inputs[5];
    assign cap_a.arm = st_q.ctrl[drive_io_pkg::CTRL_CAP_A]; // see RL12
    assign cap_b.arm = st_q.ctrl[drive_io_pkg::CTRL_CAP_B];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_q.ack && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign cap_a.clear = wr && (wb_adr_i == drive_io_pkg::ADDR_CAP_CLR) && wb_dat_i[0];
    assign cap_b.clear = wr && (wb_adr_i == drive_io_pkg::ADDR_CAP_CLR) && wb_dat_i[1];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DIN; gi++) begin : g_pol
            assign din_active[gi] = st_q.din[gi] ~^ st_q.polarity[gi]; // see RL8
        end
    endgenerate
    // In follow mode the connector pair is not used at all
    assign pulse_src = st_q.ctrl[drive_io_pkg::CTRL_FOLLOW] ?
        general_digital_inputs[4] : conn_pulse; // see RL9 RL11
    assign dir_src = st_q.ctrl[drive_io_pkg::CTRL_FOLLOW] ?
        general_digital_inputs[5] : conn_direction; // see RL11
    always_comb begin
        st_d = st_q;
        st_d.ack = 1'b0;
        st_d.step = 1'b0;
        st_d.start = 1'b0;
        st_d.ain_sw_cnt = st_q.ain_sw_cnt + 32'h1;
        st_d.ain_hs_cnt = st_q.ain_hs_cnt + 32'h1;
        st_d.din_cnt = st_q.din_cnt + 32'h1;
        if (st_q.ain_sw_cnt >= 32'(AIN_SW_CYCLES - 1)) begin
            st_d.ain_sw_cnt = 32'h0;
            st_d.ain_sw = command_analog_input; // see RL1 RL2
        end
        if (st_q.ain_hs_cnt >= 32'(AIN_HS_CYCLES - 1)) begin
            st_d.ain_hs_cnt = 32'h0;
            if (st_q.ctrl[drive_io_pkg::CTRL_AIN_HS]) begin
                st_d.ain_hs = command_analog_input; // see RL1
            end
        end
        if (st_q.din_cnt >= 32'(DIN_CYCLES - 1)) begin
            st_d.din_cnt = 32'h0;
            st_d.din = general_digital_inputs; // see RL6
            st_d.en_in = drive_enable_input; // see RL6
        end
        if (cap_a.hit) begin
            st_d.cap_axis = axis_position; // see RL12 RL14
            st_d.start = 1'b1; // see RL17
        end
        if (cap_b.hit) begin
            if (st_q.ctrl[drive_io_pkg::CTRL_CAP_B_AUX]) begin
                st_d.cap_aux = aux_position; // see RL13
            end else begin
                st_d.cap_axis = axis_position; // see RL12
            end
        end
        st_d.pulse_prev = pulse_src;
        if (pulse_src && !st_q.pulse_prev) begin
            st_d.step = 1'b1; // see RL9
        end
        st_d.fwd = dir_src; // see RL10
        if (wr && wb_adr_i == drive_io_pkg::ADDR_CTRL) begin
            st_d.ctrl = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == drive_io_pkg::ADDR_POLARITY) begin
            st_d.polarity = wb_dat_i[NUM_DIN-1:0];
        end
        if (st_d.ctrl[drive_io_pkg::CTRL_ENABLE_ASSIGN]) begin
            st_d.contact = axis_enable_state; // see RL5
        end else if (st_d.ctrl[drive_io_pkg::CTRL_FAULT_ASSIGN]) begin
            st_d.contact = !global_error; // see RL3
        end else begin
            st_d.contact = st_d.ctrl[drive_io_pkg::CTRL_CONTACT]; // see RL4
        end
        if (rd) begin
            st_d.ack = 1'b1;
            unique case (wb_adr_i)
                drive_io_pkg::ADDR_CTRL: st_d.ack_data = {24'h0, st_q.ctrl};
                drive_io_pkg::ADDR_STATUS: st_d.ack_data = {29'h0, st_q.en_in,
                    cap_b.held, cap_a.held}; // see RL16
                drive_io_pkg::ADDR_INPUTS: st_d.ack_data = 32'(din_active); // see RL7
                drive_io_pkg::ADDR_POLARITY: st_d.ack_data = 32'(st_q.polarity);
                drive_io_pkg::ADDR_AIN: st_d.ack_data = {{17{st_q.ain_sw[14]}}, st_q.ain_sw};
                drive_io_pkg::ADDR_CAP_AXIS: st_d.ack_data = 32'(st_q.cap_axis);
                drive_io_pkg::ADDR_CAP_AUX: st_d.ack_data = 32'(st_q.cap_aux);
                default: st_d.ack_data = 32'h0;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.ctrl <= drive_io_pkg::CTRL_RESET;
            st_q.polarity <= drive_io_pkg::POLARITY_RESET;
        end else begin
            st_q <= st_d;
        end
    end
    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.ack_data;
    assign contact_energize = st_q.contact;
    assign ain_fast_value = st_q.ain_hs;
    assign follow_step = st_q.step;
    assign follow_forward = st_q.fwd;
    assign move_start = st_q.start;
    assign enable_input_state = st_q.en_in;
    property p_fault_contact;
        @(posedge core_clk) disable iff (!resetn)
        (st_q.ctrl[drive_io_pkg::CTRL_FAULT_ASSIGN] && !st_q.ctrl[drive_io_pkg::CTRL_ENABLE_ASSIGN]
            && global_error && !wr) |=> !contact_energize;
    endproperty
    a_fault_contact: assert property (p_fault_contact) else $error("contact not opened"); // see RL3
    property p_enable_contact;
        @(posedge core_clk) disable iff (!resetn)
        (st_q.ctrl[drive_io_pkg::CTRL_ENABLE_ASSIGN] && !wr)
            |=> (contact_energize == $past(axis_enable_state));
    endproperty
    a_enable_contact: assert property (p_enable_contact) else $error("enable mismatch"); // see RL5
    property p_manual_contact;
        @(posedge core_clk) disable iff (!resetn)
        (wr && wb_adr_i == drive_io_pkg::ADDR_CTRL && wb_dat_i[2:0] == 3'h0)
            |=> !contact_energize;
    endproperty
    a_manual_contact: assert property (p_manual_contact) else $error("write not immediate"); // see RL4
    property p_capture_value;
        @(posedge core_clk) disable iff (!resetn)
        cap_a.hit |=> (st_q.cap_axis == $past(axis_position)) && move_start;
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture lost"); // see RL12 RL17
    property p_capture_hold;
        @(posedge core_clk) disable iff (!resetn)
        (cap_a.held && !cap_a.hit && !cap_b.hit && !cap_a.clear) |=> $stable(st_q.cap_axis);
    endproperty
    a_capture_hold: assert property (p_capture_hold) else $error("held value changed"); // see RL16
    property p_aux_only_b;
        @(posedge core_clk) disable iff (!resetn)
        !cap_b.hit |=> $stable(st_q.cap_aux);
    endproperty
    a_aux_only_b: assert property (p_aux_only_b) else $error("aux changed"); // see RL13
    property p_step_dir;
        @(posedge core_clk) disable iff (!resetn)
        st_q.ctrl[drive_io_pkg::CTRL_FOLLOW] && !wr
            |=> follow_forward == $past(general_digital_inputs[5]);
    endproperty
    a_step_dir: assert property (p_step_dir) else $error("direction wrong"); // see RL10 RL11
    property p_ack_one;
        @(posedge core_clk) disable iff (!resetn)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");
endmodule // drive_io_sampling_capture

// ==== logic/drive_io_pkg.sv ====
package drive_io_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned AIN_SW_US = 500;
    localparam int unsigned AIN_HS_US = 125;
    localparam int unsigned DIN_SAMPLE_MS = 2;
    localparam int unsigned CAP_LATENCY_US = 1;
    localparam int unsigned TRIG_MIN_US = 30;
    localparam int unsigned AIN_SW_CYC = AIN_SW_US * (CLK_HZ / 1_000_000);
    localparam int unsigned AIN_HS_CYC = AIN_HS_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DIN_SAMPLE_CYC = DIN_SAMPLE_MS * (CLK_HZ / 1_000);
    localparam int unsigned CAP_LATENCY_CYC = CAP_LATENCY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TRIG_MIN_CYC = TRIG_MIN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned AIN_W = 15;
    // Byte offsets on the bus, one word apart
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INPUTS = 8'h08;
    localparam logic [7:0] ADDR_POLARITY = 8'h0C;
    localparam logic [7:0] ADDR_AIN = 8'h10;
    localparam logic [7:0] ADDR_CAP_AXIS = 8'h14;
    localparam logic [7:0] ADDR_CAP_AUX = 8'h18;
    localparam logic [7:0] ADDR_CAP_CLR = 8'h1C;
    // Control field positions
    localparam int unsigned CTRL_CONTACT = 0;
    localparam int unsigned CTRL_FAULT_ASSIGN = 1;
    localparam int unsigned CTRL_ENABLE_ASSIGN = 2;
    localparam int unsigned CTRL_FOLLOW = 3;
    localparam int unsigned CTRL_CAP_A = 4;
    localparam int unsigned CTRL_CAP_B = 5;
    localparam int unsigned CTRL_CAP_B_AUX = 6;
    localparam int unsigned CTRL_AIN_HS = 7;
    localparam logic [7:0] CTRL_RESET = 8'h02;
    localparam logic [7:0] POLARITY_RESET = 8'hFF;
endpackage

// ==== logic/capture_if.sv ====
`timescale 1ns/10ps
interface capture_if;
    logic raw_in;
    logic arm;
    logic clear;
    logic hit;
    logic held;
    modport ctl(output raw_in, output arm, output clear, input hit, input held);
    modport cap(input raw_in, input arm, input clear, output hit, output held);
endinterface

// ==== logic/fast_capture.sv ====
`timescale 1ns/10ps
module fast_capture (
    input wire logic core_clk,
    input wire logic resetn,
    capture_if.cap cp
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic held;
        logic hit;
    } cap_s;
    cap_s st_q;
    cap_s st_d;
    always_comb begin
        st_d = st_q;
        st_d.s1 = cp.raw_in; // see RL15
        st_d.s2 = st_q.s1; // see RL18
        st_d.s3 = st_q.s2;
        st_d.hit = 1'b0;
        if (cp.clear) begin
            st_d.held = 1'b0;
        end
        // Held latch blocks further edges; an edge in the clear cycle still latches
        if (cp.arm && st_q.s2 && !st_q.s3 && (!st_q.held || cp.clear)) begin // see RL16
            st_d.hit = 1'b1; // see RL18
            st_d.held = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign cp.hit = st_q.hit;
    assign cp.held = st_q.held;
    property p_hit_latch;
        @(posedge core_clk) disable iff (!resetn)
        st_q.hit |-> st_q.held;
    endproperty
    a_hit_latch: assert property (p_hit_latch) else $error("hit without latch"); // see RL16
    property p_edge_hit;
        @(posedge core_clk) disable iff (!resetn)
        (cp.arm && st_q.s2 && !st_q.s3 && !st_q.held) |=> st_q.hit;
    endproperty
    a_edge_hit: assert property (p_edge_hit) else $error("edge missed"); // see RL18
endmodule // fast_capture

// ==== verif/field_wiring_model.sv ====
`timescale 1ns/10ps
module field_wiring_model (
    input wire logic core_clk,
    output logic [7:0] general_digital_inputs,
    output logic [14:0] command_analog_input,
    output logic [31:0] axis_position,
    output logic [31:0] aux_position,
    output logic conn_pulse,
    output logic conn_direction
);
    logic [2:0] conn_cnt_q = 3'h0;
    initial begin
        general_digital_inputs = 8'h00;
        command_analog_input = 15'h0000;
        axis_position = 32'h0000_0000;
        aux_position = 32'h0000_0000;
    end
    // Connector pair never rests, so follow mode has to ignore it
    always @(posedge core_clk) begin
        conn_cnt_q <= conn_cnt_q + 3'h1;
    end
    assign conn_pulse = conn_cnt_q[1];
    assign conn_direction = conn_cnt_q[2];
    task automatic set_din(input int idx, input logic val);
        @(posedge core_clk);
        general_digital_inputs[idx] <= val;
    endtask
    task automatic set_levels(input logic [14:0] ain, input logic [31:0] ax,
                              input logic [31:0] aux);
        @(posedge core_clk);
        command_analog_input <= ain;
        axis_position <= ax;
        aux_position <= aux;
    endtask
    // Trigger held for 100 us, well over the 30 us minimum trigger width
    task automatic fast_pulse(input int idx);
        set_din(idx, 1'b1);
        repeat (10000) @(posedge core_clk);
        set_din(idx, 1'b0);
    endtask
endmodule // field_wiring_model

// ==== verif/tb_drive_io_sampling_capture.sv ====
`timescale 1ns/10ps
module tb_drive_io_sampling_capture;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic drive_enable_input = 1'b0;
    logic global_error = 1'b0;
    logic axis_enable_state = 1'b0;
    logic [31:0] wb_dat_o, axis_position, aux_position;
    logic [14:0] command_analog_input, ain_fast_value;
    logic [7:0] general_digital_inputs;
    logic wb_ack_o, conn_pulse, conn_direction, contact_energize;
    logic follow_step, follow_forward, move_start, enable_input_state;
    int n_errors = 0;
    int checks_done = 0;
    int steps = 0;
    int starts = 0;
    int mark;
    logic [3:0] sel_mask = 4'hF;
    always #5 core_clk = ~core_clk;
    drive_io_sampling_capture #(.AIN_SW_CYCLES(20), .AIN_HS_CYCLES(10), .DIN_CYCLES(40))
        drive_io_sampling_capture_i (.core_clk, .resetn, .wb_adr_i, .wb_dat_i, .wb_dat_o,
        .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .command_analog_input,
        .general_digital_inputs, .drive_enable_input, .global_error, .axis_enable_state,
        .axis_position, .aux_position, .conn_pulse, .conn_direction, .contact_energize,
        .ain_fast_value, .follow_step, .follow_forward, .move_start, .enable_input_state);
    field_wiring_model field_wiring_model_i (.core_clk, .general_digital_inputs,
        .command_analog_input, .axis_position, .aux_position, .conn_pulse, .conn_direction);
    always @(posedge core_clk) begin
        if (follow_step === 1'b1) steps++;
        if (move_start === 1'b1) starts++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] adr, input logic we, input logic [31:0] wd,
                        output logic [31:0] rdata);
        wb_adr_i <= adr;
        wb_we_i <= we;
        wb_dat_i <= wd;
        wb_sel_i <= sel_mask;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1) begin
            @(posedge core_clk);
        end
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge core_clk);
        chk_bit(wb_ack_o, 1'b0);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] tmp;
        xfer(adr, 1'b1, wd, tmp);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] got;
        xfer(adr, 1'b0, 32'h0000_0000, got);
        chk(got, exp);
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd(drive_io_pkg::ADDR_CTRL, 32'h0000_0002);
        rd(drive_io_pkg::ADDR_POLARITY, 32'h0000_00FF);
        rd(8'h20, 32'h0000_0000);
        // Byte lane 0 disabled: the write is acknowledged but refused
        sel_mask = 4'hE;
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0000);
        sel_mask = 4'hF;
        rd(drive_io_pkg::ADDR_CTRL, 32'h0000_0002);
        global_error <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_bit(contact_energize, 1'b0);
        global_error <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk_bit(contact_energize, 1'b1);
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0000);
        chk_bit(contact_energize, 1'b0);
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0001);
        chk_bit(contact_energize, 1'b1);
        // Manual bit left on: enable assignment must still win
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0005);
        chk_bit(contact_energize, 1'b0);
        axis_enable_state <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_bit(contact_energize, 1'b1);
        drive_enable_input <= 1'b1;
        field_wiring_model_i.set_levels(15'h4ABC, 32'h1234_5678, 32'h0BAD_F00D);
        for (int i = 0; i < 8; i++) field_wiring_model_i.set_din(i, i[0] ~^ i[2]);
        repeat (100) @(posedge core_clk);
        rd(drive_io_pkg::ADDR_INPUTS, 32'h0000_00A5);
        rd(drive_io_pkg::ADDR_STATUS, 32'h0000_0004);
        chk_bit(enable_input_state, 1'b1);
        wr(drive_io_pkg::ADDR_POLARITY, 32'h0000_000F);
        rd(drive_io_pkg::ADDR_INPUTS, 32'h0000_0055);
        wr(drive_io_pkg::ADDR_POLARITY, 32'h0000_00FF);
        rd(drive_io_pkg::ADDR_AIN, 32'hFFFF_CABC);
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0080);
        field_wiring_model_i.set_levels(15'h1234, 32'h1234_5678, 32'h0BAD_F00D);
        repeat (15) @(posedge core_clk);
        chk({17'h0_0000, ain_fast_value}, 32'h0000_1234);
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0008);
        repeat (100) @(posedge core_clk);
        chk_bit(follow_forward, 1'b1);
        field_wiring_model_i.set_din(5, 1'b0);
        repeat (100) @(posedge core_clk);
        chk_bit(follow_forward, 1'b0);
        mark = steps;
        repeat (3) begin
            field_wiring_model_i.set_din(4, 1'b1);
            repeat (100) @(posedge core_clk);
            field_wiring_model_i.set_din(4, 1'b0);
            repeat (100) @(posedge core_clk);
        end
        chk(32'(steps - mark), 32'h0000_0003);
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0010);
        mark = starts;
        fork
            field_wiring_model_i.fast_pulse(4);
            begin
                repeat (94) @(posedge core_clk);
                rd(drive_io_pkg::ADDR_CAP_AXIS, 32'h1234_5678);
                rd(drive_io_pkg::ADDR_STATUS, 32'h0000_0005);
            end
        join
        chk(32'(starts - mark), 32'h0000_0001);
        field_wiring_model_i.set_levels(15'h1234, 32'h0000_0042, 32'h0BAD_F00D);
        field_wiring_model_i.fast_pulse(4);
        rd(drive_io_pkg::ADDR_CAP_AXIS, 32'h1234_5678);
        wr(drive_io_pkg::ADDR_CAP_CLR, 32'h0000_0001);
        rd(drive_io_pkg::ADDR_STATUS, 32'h0000_0004);
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0060);
        field_wiring_model_i.fast_pulse(5);
        rd(drive_io_pkg::ADDR_CAP_AUX, 32'h0BAD_F00D);
        rd(drive_io_pkg::ADDR_STATUS, 32'h0000_0006);
        // Input b in axis mode: axis value taken, aux value left alone
        wr(drive_io_pkg::ADDR_CAP_CLR, 32'h0000_0002);
        wr(drive_io_pkg::ADDR_CTRL, 32'h0000_0020);
        field_wiring_model_i.set_levels(15'h1234, 32'h0000_0099, 32'h0000_0777);
        field_wiring_model_i.fast_pulse(5);
        rd(drive_io_pkg::ADDR_CAP_AXIS, 32'h0000_0099);
        rd(drive_io_pkg::ADDR_CAP_AUX, 32'h0BAD_F00D);
        end_of_test();
    end
endmodule // tb_drive_io_sampling_capture
